// ### hw/rtd_time_date.sv
// rtd_time_date: bcd time and calendar counters with integrity and century flags
// assumes a bus front end that frames each burst with acc_busy and issues
// one-cycle reg_wr / reg_rd strobes; supply and oscillator monitors are synchronous
// Function
// - counters held as bcd, units nibble plus tens digit
// - seconds bit 7 is the voltage-low flag, set at start-up
// - seconds tens 0-5 in bits 6-4, units 0-9 in bits 3-0
// - supply-low detector sets the voltage-low flag
// - voltage-low flag clears only by register write
// - oscillator stop also sets the voltage-low flag
// - minutes bit 7 unused, tens 0-5 bits 6-4, units bits 3-0
// - hours bits 7-6 unused, tens 0-2 bits 5-4, units bits 3-0
// - days bits 7-6 unused, tens 0-3 bits 5-4, units bits 3-0
// - february has 29 days when year divisible by 4, 00 included
// - weekday three bits 0-6 in bits 2-0, upper bits unused
// - weekday is only a cyclic count, meaning left to software
// - century/months bit 7 is the century flag
// - century flag toggles when years wrap 99 to 00
// - month tens in bit 4, units bits 3-0, 01 to 12
// - years as two bcd digits, tens bits 7-4, units 3-0
// - counting frozen during access; one pending tick kept and applied after
`timescale 1ns/1ps
module rtd_time_date
  import rtd_pkg::*;
#(
  parameter int TICK_DIV = rtd_pkg::TICK_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic acc_busy,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic supply_low,
  input wire logic osc_stopped,
  output logic voltage_low_flag,
  output logic tick_pending
);
  import rtd_pkg::*;

  initial begin
    if (TICK_DIV < 2) begin
      $error("TICK_DIV must be at least 2");
    end
    // the write decode assumes the seven time registers sit back to back
    if (ADDR_YEARS - ADDR_SECONDS != 8'h06) begin
      $error("time registers must be contiguous");
    end
  end

  // ************************************************************
  // bcd helpers
  // ************************************************************
  // increments a two-digit bcd value, wrapping to first after last
  function automatic logic [7:0] bcd_inc(input logic [7:0] v, input logic [7:0] last, input logic [7:0] first);
    logic [7:0] r;
    r = v;
    if (v >= last) begin
      r = first;
    end else if (v[3:0] >= 4'h9) begin
      r = {v[7:4] + 4'h1, 4'h0};
    end else begin
      r = {v[7:4], v[3:0] + 4'h1};
    end
    return r;
  endfunction

  // ************************************************************
  // one second divider
  // ************************************************************
  logic [31:0] div_cnt;
  logic [31:0] next_div_cnt;
  logic sec_tick;

  always_comb begin
    sec_tick = (div_cnt == 32'(TICK_DIV - 1));
    next_div_cnt = sec_tick ? 32'h0 : div_cnt + 32'h1;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      div_cnt <= 32'h0;
    end else begin
      div_cnt <= next_div_cnt;
    end
  end

  // ************************************************************
  // time and date state
  // ************************************************************
  // bcd digits, unused bits not stored
  logic [6:0] sec;
  logic [6:0] min;
  logic [5:0] hour;
  logic [5:0] day;
  logic [2:0] wday;
  logic [4:0] month;
  logic [7:0] year;
  logic century;
  logic vl;
  logic pend;
  logic [6:0] next_sec;
  logic [6:0] next_min;
  logic [5:0] next_hour;
  logic [5:0] next_day;
  logic [2:0] next_wday;
  logic [4:0] next_month;
  logic [7:0] next_year;
  logic next_century;
  logic next_vl;
  logic next_pend;
  logic [7:0] month_len;
  logic advance;
  logic leap_year;
  logic [7:0] sec_inc;
  logic [7:0] min_inc;
  logic [7:0] hour_inc;
  logic [7:0] day_inc;
  logic [7:0] month_inc;
  logic [7:0] year_inc;
  logic [2:0] wday_inc;
  logic sec_wrap;
  logic min_wrap;
  logic hour_wrap;
  logic day_wrap;
  logic month_wrap;
  logic year_wrap;

  // ************************************************************
  // calendar limits
  // ************************************************************
  // bcd year divisible by 4: even tens with units 0/4/8, odd tens with 2/6
  always_comb begin
    leap_year = (year[4] == 1'b0 && year[1:0] == 2'b00) || (year[4] == 1'b1 && year[1:0] == 2'b10);
  end

  always_comb begin
    unique case ({3'h0, month})
      MONTH_FEB: month_len = leap_year ? DAYS_29 : DAYS_28;
      MONTH_APR, MONTH_JUN, MONTH_SEP, MONTH_NOV: month_len = DAYS_30;
      default: month_len = DAYS_31;
    endcase
  end

  // ************************************************************
  // per-field increments
  // ************************************************************
  // successors worked out in parallel; the carry chain only picks
  always_comb begin
    sec_inc = bcd_inc({1'b0, sec}, SEC_LAST, 8'h00);
    min_inc = bcd_inc({1'b0, min}, MIN_LAST, 8'h00);
    hour_inc = bcd_inc({2'b0, hour}, HOUR_LAST, 8'h00);
    day_inc = bcd_inc({2'b0, day}, month_len, DAY_FIRST);
    month_inc = bcd_inc({3'b0, month}, MONTH_LAST, MONTH_FIRST);
    year_inc = bcd_inc(year, YEAR_LAST, 8'h00);
    // weekday cycles 0..6 regardless of meaning
    wday_inc = (wday >= WDAY_LAST) ? 3'h0 : wday + 3'h1;
    // out-of-range values wrap too, so a bad write cannot stall the calendar
    sec_wrap = ({1'b0, sec} >= SEC_LAST);
    min_wrap = ({1'b0, min} >= MIN_LAST);
    hour_wrap = ({2'b0, hour} >= HOUR_LAST);
    day_wrap = ({2'b0, day} >= month_len);
    month_wrap = ({3'b0, month} >= MONTH_LAST);
    // only a true 99 to 00 step flips the century
    year_wrap = (year == YEAR_LAST);
  end

  // ************************************************************
  // write decode
  // ************************************************************
  logic wr_sec;
  logic wr_min;
  logic wr_hour;
  logic wr_day;
  logic wr_wday;
  logic wr_month;
  logic wr_year;

  // decoded once so the update below stays a plain priority list
  always_comb begin
    wr_sec = reg_wr && reg_addr == ADDR_SECONDS;
    wr_min = reg_wr && reg_addr == ADDR_MINUTES;
    wr_hour = reg_wr && reg_addr == ADDR_HOURS;
    wr_day = reg_wr && reg_addr == ADDR_DAYS;
    wr_wday = reg_wr && reg_addr == ADDR_WEEKDAY;
    wr_month = reg_wr && reg_addr == ADDR_CENT_MONTH;
    wr_year = reg_wr && reg_addr == ADDR_YEARS;
  end

  always_comb begin
    next_sec = sec;
    next_min = min;
    next_hour = hour;
    next_day = day;
    next_wday = wday;
    next_month = month;
    next_year = year;
    next_century = century;
    next_vl = vl;
    next_pend = pend;
    // freeze while busy; remember one tick
    advance = 1'b0;
    if (acc_busy) begin
      if (sec_tick) begin
        next_pend = 1'b1;
      end
    end else if (sec_tick || pend) begin
      advance = 1'b1;
      next_pend = 1'b0;
    end
    if (advance) begin
      next_sec = sec_inc[6:0];
      if (sec_wrap) begin
        next_min = min_inc[6:0];
        if (min_wrap) begin
          next_hour = hour_inc[5:0];
          if (hour_wrap) begin
            next_wday = wday_inc;
            next_day = day_inc[5:0];
            if (day_wrap) begin
              next_month = month_inc[4:0];
              if (month_wrap) begin
                next_year = year_inc;
                if (year_wrap) begin
                  next_century = ~century;
                end
              end
            end
          end
        end
      end
    end
    // writes keep only defined field bits; a write beats an advance
    if (wr_sec) begin
      next_sec = reg_wdata[6:0] & SEC_MASK;
      next_vl = reg_wdata[VL_BIT];
    end
    if (wr_min) begin
      next_min = reg_wdata[6:0] & MIN_MASK;
    end
    if (wr_hour) begin
      next_hour = reg_wdata[5:0] & HOUR_MASK;
    end
    if (wr_day) begin
      next_day = reg_wdata[5:0] & DAY_MASK;
    end
    if (wr_wday) begin
      next_wday = reg_wdata[2:0] & WDAY_MASK;
    end
    if (wr_month) begin
      next_century = reg_wdata[CENTURY_BIT];
      next_month = reg_wdata[4:0] & MONTH_MASK;
    end
    if (wr_year) begin
      next_year = reg_wdata;
    end
    // monitors win over a clearing write
    if (supply_low || osc_stopped) begin
      next_vl = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      // flag set at start-up; counters take a defined value
      vl <= 1'b1;
      sec <= 7'h00;
      min <= 7'h00;
      hour <= 6'h00;
      day <= 6'h01;
      wday <= 3'h0;
      month <= 5'h01;
      year <= 8'h00;
      century <= 1'b0;
      pend <= 1'b0;
    end else begin
      vl <= next_vl;
      sec <= next_sec;
      min <= next_min;
      hour <= next_hour;
      day <= next_day;
      wday <= next_wday;
      month <= next_month;
      year <= next_year;
      century <= next_century;
      pend <= next_pend;
    end
  end

  // ************************************************************
  // read data
  // ************************************************************
  logic [7:0] next_rdata;

  // unused bits read as zero; data registered on reg_rd
  always_comb begin
    next_rdata = reg_rdata;
    if (reg_rd) begin
      unique case (reg_addr)
        ADDR_SECONDS: next_rdata = {vl, sec};
        ADDR_MINUTES: next_rdata = {1'b0, min};
        ADDR_HOURS: next_rdata = {2'b0, hour};
        ADDR_DAYS: next_rdata = {2'b0, day};
        ADDR_WEEKDAY: next_rdata = {5'b0, wday};
        ADDR_CENT_MONTH: next_rdata = {century, 2'b0, month};
        ADDR_YEARS: next_rdata = year;
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

  assign voltage_low_flag = vl;
  assign tick_pending = pend;
endmodule

// ### hw/rtd_pkg.sv
// rtd_pkg: register map, field positions and timing constants of the time/date block
// assumes an 8-bit word-addressed register port driven by a serial bus front end
package rtd_pkg;
  localparam logic [7:0] ADDR_SECONDS = 8'h02;
  localparam logic [7:0] ADDR_MINUTES = 8'h03;
  localparam logic [7:0] ADDR_HOURS = 8'h04;
  localparam logic [7:0] ADDR_DAYS = 8'h05;
  localparam logic [7:0] ADDR_WEEKDAY = 8'h06;
  localparam logic [7:0] ADDR_CENT_MONTH = 8'h07;
  localparam logic [7:0] ADDR_YEARS = 8'h08;
  localparam int VL_BIT = 7;
  localparam int CENTURY_BIT = 7;
  localparam logic [6:0] SEC_MASK = 7'h7f;
  localparam logic [6:0] MIN_MASK = 7'h7f;
  localparam logic [5:0] HOUR_MASK = 6'h3f;
  localparam logic [5:0] DAY_MASK = 6'h3f;
  localparam logic [2:0] WDAY_MASK = 3'h7;
  localparam logic [4:0] MONTH_MASK = 5'h1f;
  localparam logic [7:0] SEC_LAST = 8'h59;
  localparam logic [7:0] MIN_LAST = 8'h59;
  localparam logic [7:0] HOUR_LAST = 8'h23;
  localparam logic [2:0] WDAY_LAST = 3'h6;
  localparam logic [7:0] MONTH_LAST = 8'h12;
  localparam logic [7:0] YEAR_LAST = 8'h99;
  localparam logic [7:0] DAY_FIRST = 8'h01;
  localparam logic [7:0] MONTH_FIRST = 8'h01;
  localparam logic [7:0] MONTH_FEB = 8'h02;
  localparam logic [7:0] MONTH_APR = 8'h04;
  localparam logic [7:0] MONTH_JUN = 8'h06;
  localparam logic [7:0] MONTH_SEP = 8'h09;
  localparam logic [7:0] MONTH_NOV = 8'h11;
  localparam logic [7:0] DAYS_31 = 8'h31;
  localparam logic [7:0] DAYS_30 = 8'h30;
  localparam logic [7:0] DAYS_29 = 8'h29;
  localparam logic [7:0] DAYS_28 = 8'h28;
  localparam int CLK_HZ = 250_000_000;
  localparam int TICK_HZ = 1;
  localparam int TICK_CYCLES = CLK_HZ / TICK_HZ;
endpackage

// ### tb/rtd_time_date_chk.sv
// rtd_time_date_chk: port-level assertions for the time/date block
// assumes it is bound onto rtd_time_date with a single clock domain
`timescale 1ns/1ps
module rtd_time_date_chk
  import rtd_pkg::*;
#(
  parameter int TICK_DIV = 10
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic acc_busy,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic supply_low,
  input wire logic osc_stopped,
  input wire logic voltage_low_flag,
  input wire logic tick_pending
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  property p_set; supply_low || osc_stopped |=> voltage_low_flag; endproperty
  a_set: assert property (p_set) else $error("flag not set");
  property p_hold; voltage_low_flag && !(reg_wr && reg_addr == ADDR_SECONDS) |=> voltage_low_flag; endproperty
  a_hold: assert property (p_hold) else $error("flag lost");
  property p_clr;
    reg_wr && reg_addr == ADDR_SECONDS && !reg_wdata[VL_BIT] && !supply_low && !osc_stopped |=> !voltage_low_flag;
  endproperty
  a_clr: assert property (p_clr) else $error("flag not cleared");
  property p_prise; $rose(tick_pending) |-> $past(acc_busy); endproperty
  a_prise: assert property (p_prise) else $error("pending while idle");
  property p_pheld; tick_pending && acc_busy |=> tick_pending; endproperty
  a_pheld: assert property (p_pheld) else $error("pending dropped");
  property p_pdone; tick_pending && !acc_busy |=> !tick_pending; endproperty
  a_pdone: assert property (p_pdone) else $error("pending kept");
  property p_rflag; reg_rd && reg_addr == ADDR_SECONDS |=> reg_rdata[7] == $past(voltage_low_flag); endproperty
  a_rflag: assert property (p_rflag) else $error("flag bit wrong");
  property p_wday; reg_rd && reg_addr == ADDR_WEEKDAY |=> reg_rdata[7:3] == 5'h00; endproperty
  a_wday: assert property (p_wday) else $error("weekday upper bits");
  property p_keep; !reg_rd |=> $stable(reg_rdata); endproperty
  a_keep: assert property (p_keep) else $error("read data moved");
endmodule
bind rtd_time_date rtd_time_date_chk #(.TICK_DIV(TICK_DIV)) i_rtd_time_date_chk(.core_clk(core_clk), .rst(rst),
  .acc_busy(acc_busy), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .supply_low(supply_low), .osc_stopped(osc_stopped),
  .voltage_low_flag(voltage_low_flag), .tick_pending(tick_pending));

// ### tb/rtd_bus_model.sv
// rtd_bus_model: serial-bus front end seen as bursts of register strokes
// assumes strobes sampled on rising core_clk, read data one cycle later
`timescale 1ns/1ps
module rtd_bus_model (
  input wire logic core_clk,
  input wire logic [7:0] reg_rdata,
  output logic acc_busy,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata
);
  initial {acc_busy, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
  // whole time set framed by one burst
  task automatic burst(input logic b);
    @(posedge core_clk);
    #1 acc_busy = b;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    #1 {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
    @(posedge core_clk);
    // stale data inverted so it is never mistaken for a valid byte
    #1 {reg_wr, reg_wdata} = {1'b0, ~d};
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    #1 {reg_rd, reg_addr} = {1'b1, a};
    @(posedge core_clk);
    #1 reg_rd = 1'b0;
    d = reg_rdata;
  endtask
endmodule

// ### tb/tb_rtd_time_date.sv
// tb_rtd_time_date: directed checks of counting, carries and integrity flag
// assumes a shortened tick divider so that ticks come every few cycles
`timescale 1ns/1ps
module tb_rtd_time_date;
  import rtd_pkg::*;
  localparam int DIV = 20;
  logic core_clk = 0;
  logic rst = 1;
  logic supply_low = 0;
  logic osc_stopped = 0;
  logic acc_busy, reg_wr, reg_rd, voltage_low_flag, tick_pending;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, got;
  int num_errors = 0;
  int checks = 0;
  initial forever #2 core_clk = ~core_clk;
  rtd_time_date #(.TICK_DIV(DIV)) i_rtd_time_date(.core_clk(core_clk), .rst(rst), .acc_busy(acc_busy),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .supply_low(supply_low), .osc_stopped(osc_stopped), .voltage_low_flag(voltage_low_flag),
    .tick_pending(tick_pending));
  rtd_bus_model u_mst(.core_clk(core_clk), .reg_rdata(reg_rdata), .acc_busy(acc_busy), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata));
  task automatic cmp(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] exp);
    u_mst.rd(a, got);
    cmp(got, exp);
  endtask
  task automatic summarize;
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // ****
  // one tick held over a burst; extra cycles let a second tick be lost
  // ****
  task automatic carry(input logic [7:0] d, m, y, ed, em, ey, input int extra);
    int n;
    n = 0;
    u_mst.burst(1);
    u_mst.wr(ADDR_SECONDS, 8'h59);
    u_mst.wr(ADDR_MINUTES, 8'hd9);
    u_mst.wr(ADDR_HOURS, 8'he3);
    u_mst.wr(ADDR_DAYS, d | 8'hc0);
    u_mst.wr(ADDR_WEEKDAY, 8'hfe);
    u_mst.wr(ADDR_CENT_MONTH, m | 8'h60);
    u_mst.wr(ADDR_YEARS, y);
    while (tick_pending !== 1'b1 && n < 3 * DIV) begin
      @(posedge core_clk);
      n++;
    end
    cmp({7'h00, tick_pending}, 8'h01);
    repeat (extra) @(posedge core_clk);
    rc(ADDR_SECONDS, 8'h59);
    u_mst.burst(0);
    u_mst.burst(1);
    rc(ADDR_SECONDS, 8'h00);
    rc(ADDR_MINUTES, 8'h00);
    rc(ADDR_HOURS, 8'h00);
    rc(ADDR_DAYS, ed);
    rc(ADDR_WEEKDAY, 8'h00);
    rc(ADDR_CENT_MONTH, em);
    rc(ADDR_YEARS, ey);
    u_mst.burst(0);
  endtask
  task automatic flag_chk;
    u_mst.burst(1);
    for (int i = 0; i < 2; i++) begin
      u_mst.wr(ADDR_SECONDS, 8'h00);
      rc(ADDR_SECONDS, 8'h00);
      {supply_low, osc_stopped} = i ? 2'b01 : 2'b10;
      @(posedge core_clk);
      #1 {supply_low, osc_stopped} = 2'b00;
      repeat (4) @(posedge core_clk);
      rc(ADDR_SECONDS, 8'h80);
    end
    u_mst.burst(0);
  endtask
  initial begin
    repeat (5000) @(posedge core_clk);
    num_errors++;
    summarize;
  end
  initial begin
    repeat (12) @(posedge core_clk);
    #1 rst = 0;
    u_mst.burst(1);
    rc(ADDR_SECONDS, 8'h80);
    rc(8'h01, 8'h00);
    rc(8'h09, 8'h00);
    u_mst.burst(0);
    carry(8'h31, 8'h12, 8'h99, 8'h01, 8'h81, 8'h00, 4);
    carry(8'h28, 8'h82, 8'h00, 8'h29, 8'h82, 8'h00, DIV + 4);
    carry(8'h28, 8'h02, 8'h01, 8'h01, 8'h03, 8'h01, 4);
    carry(8'h30, 8'h04, 8'h04, 8'h01, 8'h05, 8'h04, 4);
    flag_chk;
    summarize;
  end
endmodule
